// ---- src/pmce_engine.sv ----
// Calculation engine: sequencer, arithmetic, registers, AXI4-Lite slave
`timescale 1ns/1ns
module pmce_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pmce_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pmce_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic adc_start,
	output logic [1:0] adc_sel,
	input wire logic adc_done,
	input wire pmce_pkg::pmce_adc_res_t adc_res,
	output logic irq
);
	import pmce_pkg::*;

	// ***********************************
	// Declarations
	// ***********************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_FIN = 4'b1000
	} pmce_state_t;

	pmce_state_t state_q;
	pmce_cfg_t cfg_q, cfg_new;
	logic [CAL_W-1:0] cal_q;
	logic [1:0] sel_q, nxt_sel;
	logic [CNT_W-1:0] samp_q, samp_max;
	logic [3:0] shift;
	logic last_in, restart, cal_zero, ech_clr;
	pmce_adc_res_t r_q;
	logic r_v_q, r_last_q, ld_q, rdy_q;
	logic signed [PROD_W-1:0] prod;
	logic signed [CUR_W-1:0] cur_now, cur_last_q, raw_ext;
	logic signed [CUR_W-1:0] avg_cur, avg_bus, avg_tmp;
	logic signed [CUR_W-1:0] cur_out_q, bus_out_q, tmp_out_q;
	logic signed [POW_W-1:0] pow_now, pow_out_q;
	logic signed [EN_W-1:0] ener_q;
	logic signed [CH_W-1:0] chrg_q;
	logic [IRQ_W-1:0] ist_q, imask_q, ev;
	logic aw_h_q, w_h_q, s_axi_wstrb_q0;
	logic [AW-1:0] awaddr_q;
	logic [31:0] wdata_q, rd_val;
	logic wr_go, rd_go, rd_diag, cfg_wr, rd_hit;

	// ***********************************
	// Sequencer
	// ***********************************
	assign shift = avg_shift(cfg_q.avg);
	assign samp_max = CNT_W'((1 << shift) - 1);
	assign restart = cfg_wr;
	assign cal_zero = (cal_q == '0);

	// Next enabled input after sel_q; NONE when the sequence is over
	always_comb begin
		nxt_sel = SEL_NONE;
		unique case (sel_q)
			SEL_SHUNT: nxt_sel = cfg_q.bus_en ? SEL_BUS :
				(cfg_q.temp_en ? SEL_TEMP : SEL_NONE);
			SEL_BUS: nxt_sel = cfg_q.temp_en ? SEL_TEMP : SEL_NONE;
			SEL_TEMP, SEL_NONE: nxt_sel = SEL_NONE;
		endcase
	end

	function automatic logic [1:0] first_sel(input pmce_cfg_t c);
		first_sel = c.shunt_en ? SEL_SHUNT : c.bus_en ? SEL_BUS :
			c.temp_en ? SEL_TEMP : SEL_NONE;
	endfunction

	assign last_in = (nxt_sel == SEL_NONE) && (samp_q == samp_max);
	assign adc_start = (state_q == ST_START);
	assign adc_sel = sel_q;

	// One input at a time; a new start only after the previous result or a config write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			sel_q <= SEL_NONE;
			samp_q <= '0;
		end else if (restart) begin
			// Settings being written, not the old ones, pick the input
			sel_q <= first_sel(cfg_new);
			samp_q <= '0;
			state_q <= (first_sel(cfg_new) == SEL_NONE) ? ST_IDLE : ST_START;
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_START: state_q <= ST_WAIT;
				ST_WAIT: begin
					if (adc_done) begin
						if (nxt_sel != SEL_NONE) begin
							sel_q <= nxt_sel;
							state_q <= ST_START;
						end else begin
							sel_q <= first_sel(cfg_q);
							samp_q <= last_in ? '0 : samp_q + 1'b1;
							state_q <= last_in ? ST_FIN : ST_START;
						end
					end
				end
				// Lasts one cycle; triggered mode goes to idle, continuous mode starts again
				ST_FIN: state_q <= cfg_q.cont ? ST_START : ST_IDLE;
			endcase
		end
	end

	// ***********************************
	// Arithmetic pipeline
	// ***********************************
	// Result is captured, so the converter runs on while math proceeds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_v_q <= 1'b0;
			r_last_q <= 1'b0;
			r_q <= '0;
			ld_q <= 1'b0;
		end else begin
			r_v_q <= adc_done && (state_q == ST_WAIT) && !restart;
			r_last_q <= last_in;
			if (adc_done) begin
				r_q <= adc_res;
			end
			ld_q <= r_v_q && r_last_q && !restart;
		end
	end

	assign prod = r_q.data * $signed({1'b0, cal_q});
	assign cur_now = prod[CUR_SHIFT+CUR_W-1:CUR_SHIFT];
	assign raw_ext = CUR_W'(r_q.data);
	assign pow_now = cur_last_q * r_q.data;

	pmce_avg_acc #(.W(CUR_W)) u_acc_cur (.aclk, .aresetn, .shift,
		.clr(ld_q || restart),
		.add(r_v_q && r_q.sel == SEL_SHUNT),
		.din(cur_now), .avg(avg_cur));
	pmce_avg_acc #(.W(CUR_W)) u_acc_bus (.aclk, .aresetn, .shift,
		.clr(ld_q || restart),
		.add(r_v_q && r_q.sel == SEL_BUS),
		.din(raw_ext), .avg(avg_bus));
	pmce_avg_acc #(.W(CUR_W)) u_acc_tmp (.aclk, .aresetn, .shift,
		.clr(ld_q || restart),
		.add(r_v_q && r_q.sel == SEL_TEMP),
		.din(raw_ext), .avg(avg_tmp));

	// Energy and charge bypass averaging; a clear write wins, else charge grows on each shunt conversion, energy on each bus conversion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_last_q <= '0;
			ener_q <= '0;
			chrg_q <= '0;
		end else if (ech_clr) begin
			ener_q <= '0;
			chrg_q <= '0;
		end else if (r_v_q && r_q.sel == SEL_SHUNT) begin
			cur_last_q <= cur_now;
			chrg_q <= chrg_q + CH_W'(cur_now);
		end else if (r_v_q && r_q.sel == SEL_BUS) begin
			ener_q <= ener_q + EN_W'(pow_now);
		end
	end

	// Averages, with one sample equal to the calibrated current or the raw value, then power
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_out_q <= '0;
			bus_out_q <= '0;
			tmp_out_q <= '0;
			pow_out_q <= '0;
		end else if (ld_q) begin
			cur_out_q <= avg_cur;
			bus_out_q <= avg_bus;
			tmp_out_q <= avg_tmp;
			pow_out_q <= avg_cur * avg_bus;
		end
	end

	// ***********************************
	// Flags and interrupt
	// ***********************************
	assign ev[IRQ_SEQ] = ld_q;
	assign ev[IRQ_CONV] = r_v_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdy_q <= 1'b0;
		end else if (ld_q) begin
			rdy_q <= 1'b1;
		end else if (rd_diag || cfg_wr) begin
			rdy_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_q <= '0;
		end else if (wr_go && awaddr_q == ADDR_ISTAT) begin
			ist_q <= (ist_q & ~wdata_q[IRQ_W-1:0]) | ev;
		end else begin
			ist_q <= ist_q | ev;
		end
	end

	assign irq = |(ist_q & imask_q);

	// ***********************************
	// AXI4-Lite slave
	// ***********************************
	// Ready while nothing is held or answered open, no framing select gates access
	assign s_axi_awready = !aw_h_q;
	assign s_axi_wready = !w_h_q;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_h_q && w_h_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_diag = rd_go && s_axi_araddr == ADDR_DIAG;
	assign cfg_wr = wr_go && awaddr_q == ADDR_CFG && s_axi_wstrb_q0;
	assign cfg_new = wdata_q[CFG_W-1:0];
	assign ech_clr = wr_go && awaddr_q == ADDR_ACLR && wdata_q[ACLR_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h_q <= 1'b0;
			w_h_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			s_axi_wstrb_q0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_h_q) begin
				aw_h_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_h_q) begin
				w_h_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				s_axi_wstrb_q0 <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_h_q <= 1'b0;
				w_h_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q > ADDR_ACLR || awaddr_q[1:0] != 2'h0)
					? RESP_DECERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Low byte lane gates config and mask; calibration ignores it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= CFG_RST;
			cal_q <= '0;
			imask_q <= '0;
		end else if (wr_go) begin
			if (cfg_wr) begin
				cfg_q <= cfg_new;
			end
			if (s_axi_wstrb_q0 && awaddr_q == ADDR_IMASK) begin
				imask_q <= wdata_q[IRQ_W-1:0];
			end
			if (awaddr_q == ADDR_CAL) begin
				cal_q <= wdata_q[CAL_W-1:0];
			end
		end
	end

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_CFG: rd_val = 32'(cfg_q);
			ADDR_CAL: rd_val = 32'(cal_q);
			ADDR_DIAG: begin
				rd_val[DIAG_RDY] = rdy_q;
				rd_val[DIAG_VALID] = cfg_q.cont;
			end
			ADDR_ISTAT: rd_val = 32'(ist_q);
			ADDR_IMASK: rd_val = 32'(imask_q);
			ADDR_CUR: rd_val = 32'(cur_out_q);
			ADDR_BUS_VOLTAGE_INPUT: rd_val = 32'(bus_out_q);
			ADDR_TEMP: rd_val = 32'(tmp_out_q);
			ADDR_POW: rd_val = cal_zero ? '0 : pow_out_q[POW_W-1 -: 32];
			ADDR_ENER: rd_val = cal_zero ? '0 : ener_q[EN_W-1 -: 32];
			ADDR_CHRG: rd_val = cal_zero ? '0 : chrg_q[CH_W-1 -: 32];
			ADDR_ACLR: rd_val = '0;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ---- src/pmce_pkg.sv ----
// Shared constants and types of the power monitor calculation engine
package pmce_pkg;

	// ***********************************
	// Register map (byte addresses)
	// ***********************************
	localparam int AW = 8;
	localparam logic [AW-1:0] ADDR_CFG = 8'h00;
	localparam logic [AW-1:0] ADDR_CAL = 8'h04;
	localparam logic [AW-1:0] ADDR_DIAG = 8'h08;
	localparam logic [AW-1:0] ADDR_ISTAT = 8'h0c;
	localparam logic [AW-1:0] ADDR_IMASK = 8'h10;
	localparam logic [AW-1:0] ADDR_CUR = 8'h14;
	localparam logic [AW-1:0] ADDR_BUS_VOLTAGE_INPUT = 8'h18;
	localparam logic [AW-1:0] ADDR_TEMP = 8'h1c;
	localparam logic [AW-1:0] ADDR_POW = 8'h20;
	localparam logic [AW-1:0] ADDR_ENER = 8'h24;
	localparam logic [AW-1:0] ADDR_CHRG = 8'h28;
	localparam logic [AW-1:0] ADDR_ACLR = 8'h2c;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ***********************************
	// Fields and widths
	// ***********************************
	typedef struct packed {
		logic [2:0] avg;
		logic cont;
		logic temp_en;
		logic bus_en;
		logic shunt_en;
	} pmce_cfg_t;
	localparam int CFG_W = 7;
	localparam logic [CFG_W-1:0] CFG_RST = 7'h0f;

	localparam int RAW_W = 20;
	localparam int CAL_W = 15;
	localparam int CUR_W = 24;
	localparam int CUR_SHIFT = 11;
	localparam int PROD_W = RAW_W + CAL_W + 1;
	localparam int POW_W = CUR_W + RAW_W;
	localparam int EN_W = 48;
	localparam int CH_W = 40;
	localparam int CNT_W = 10;

	// Input select codes; NONE ends a sequence
	localparam logic [1:0] SEL_SHUNT = 2'h0;
	localparam logic [1:0] SEL_BUS = 2'h1;
	localparam logic [1:0] SEL_TEMP = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;

	typedef struct packed {
		logic [1:0] sel;
		logic signed [RAW_W-1:0] data;
	} pmce_adc_res_t;

	localparam int IRQ_W = 2;
	localparam int IRQ_SEQ = 0;
	localparam int IRQ_CONV = 1;
	localparam int DIAG_RDY = 0;
	localparam int DIAG_VALID = 1;
	localparam int ACLR_BIT = 0;

	// Averaging code to log2 of the sample count: 1,4,16,64,128,256,512,1024
	function automatic logic [3:0] avg_shift(input logic [2:0] code);
		case (code)
			3'h0: avg_shift = 4'h0;
			3'h1: avg_shift = 4'h2;
			3'h2: avg_shift = 4'h4;
			3'h3: avg_shift = 4'h6;
			3'h4: avg_shift = 4'h7;
			3'h5: avg_shift = 4'h8;
			3'h6: avg_shift = 4'h9;
			default: avg_shift = 4'ha;
		endcase
	endfunction

endpackage

// ---- src/pmce_avg_acc.sv ----
// Averaging accumulator for one measured quantity
`timescale 1ns/1ns
module pmce_avg_acc #(
	parameter int W = 24
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic add,
	input wire logic signed [W-1:0] din,
	input wire logic [3:0] shift,
	output logic signed [W-1:0] avg
);
	import pmce_pkg::*;

	localparam int SW = W + CNT_W;
	logic signed [SW-1:0] sum_q;
	logic signed [SW-1:0] base;
	logic signed [SW-1:0] shifted;

	// Count is a power of two, so the divide is an arithmetic shift
	assign shifted = sum_q >>> shift;
	assign avg = shifted[W-1:0];
	assign base = clr ? '0 : sum_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sum_q <= '0;
		end else if (add) begin
			sum_q <= base + SW'(din);
		end else if (clr) begin
			sum_q <= '0;
		end
	end

endmodule

// ---- testbench/pmce_chk.sv ----
// Port checks for the calculation engine
`timescale 1ns/1ns
module pmce_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic adc_start,
	input wire logic [1:0] adc_sel,
	input wire logic adc_done,
	input wire logic irq
);
	import pmce_pkg::*;
	logic busy_q;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic quiet;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign quiet = !s_axi_bvalid && !s_axi_rvalid && !adc_start && !irq;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A write may restart the sequencer, so it ends the tracking
	always_ff @(posedge aclk) begin
		if (!aresetn || aw_hs)
			busy_q <= 1'b0;
		else if (adc_start)
			busy_q <= 1'b1;
		else if (adc_done)
			busy_q <= 1'b0;
	end
	start_pulse_a: assert property (adc_start |=> !adc_start)
		else $error("start pulse too long");
	one_input_a: assert property (adc_start |-> adc_sel != SEL_NONE)
		else $error("start with no input");
	serial_conv_a: assert property (busy_q |-> !adc_start)
		else $error("start during conversion");
	sel_hold_a: assert property (busy_q && !adc_done |-> $stable(adc_sel))
		else $error("input select moved");
	write_ans_a: assert property (aw_hs && w_hs |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	read_ans_a: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer open");
	reset_a: assert property (disable iff (1'b0) !aresetn |=> quiet)
		else $error("outputs active after reset");
endmodule
bind pmce_engine pmce_chk u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .adc_start, .adc_sel, .adc_done, .irq
);

// ---- testbench/pmce_adc_model.sv ----
// Behavioural converter answering the engine's start pulses
`timescale 1ns/1ns
module pmce_adc_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic adc_start,
	input wire logic [1:0] adc_sel,
	input wire logic slow,
	input wire logic signed [pmce_pkg::RAW_W-1:0] v_sh,
	input wire logic signed [pmce_pkg::RAW_W-1:0] v_bus,
	input wire logic signed [pmce_pkg::RAW_W-1:0] v_tmp,
	output logic adc_done,
	output pmce_pkg::pmce_adc_res_t adc_res
);
	import pmce_pkg::*;
	logic busy_q;
	logic [1:0] sel_q;
	logic [5:0] cnt_q;
	// Result bus toggles between results, so stale data never looks valid
	always_ff @(posedge aclk) begin
		adc_done <= 1'b0;
		adc_res <= ~adc_res;
		if (!aresetn) begin
			busy_q <= 1'b0;
			adc_res <= '0;
		end else if (adc_start) begin
			busy_q <= 1'b1;
			sel_q <= adc_sel;
			cnt_q <= slow ? 6'h28 : 6'h04;
		end else if (busy_q && cnt_q == 6'h00) begin
			busy_q <= 1'b0;
			adc_done <= 1'b1;
			adc_res.sel <= sel_q;
			adc_res.data <= sel_q == SEL_SHUNT ? v_sh :
				sel_q == SEL_BUS ? v_bus : v_tmp;
		end else begin
			cnt_q <= cnt_q - 6'h01;
		end
	end
endmodule

// ---- testbench/power_monitor_calc_engine_tb_top.sv ----
// Register-level test of the calculation engine
`timescale 1ns/1ns
module power_monitor_calc_engine_tb_top;
	import pmce_pkg::*;
	localparam logic signed [RAW_W-1:0] S = 20'h00100;
	localparam logic signed [RAW_W-1:0] B = 20'h01000;
	localparam logic signed [RAW_W-1:0] T = 20'h00c80;
	localparam logic [31:0] CAL = 32'h00000800;
	localparam longint C = (longint'(S) * CAL) >>> 11;
	localparam longint P = C * longint'(B);
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic slow = 1'b0;
	logic [AW-1:0] s_axi_awaddr = '0;
	logic [AW-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, adc_start, adc_done, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, adc_sel, rr;
	logic [31:0] s_axi_rdata, rv;
	pmce_adc_res_t adc_res;
	int n_errors = 0;
	int n_checks = 0;
	always #2 aclk = ~aclk;
	pmce_engine dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .adc_start, .adc_sel, .adc_done,
		.adc_res, .irq
	);
	pmce_adc_model adc (
		.aclk, .aresetn, .adc_start, .adc_sel, .slow, .v_sh(S),
		.v_bus(B), .v_tmp(T), .adc_done, .adc_res
	);
	// *******
	// Tasks
	// *******
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tmo();
		n_errors++;
		$display("ERROR %0t wait ran out", $time);
		conclude();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Handshakes judged at the falling edge, acted on at the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic ah, wh, bh;
		bh = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 50 && !bh; i++) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge aclk);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
		end
		if (!bh)
			tmo();
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		int i;
		logic ah, h;
		h = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 50 && !h; i++) begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			h = s_axi_rvalid;
			rv = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (ah)
				s_axi_arvalid <= 1'b0;
		end
		if (!h)
			tmo();
		chk(rv & m, e);
	endtask
	task automatic wait_irq();
		int i;
		logic h;
		h = 1'b0;
		for (i = 0; i < 4000 && !h; i++) begin
			@(negedge aclk);
			h = irq === 1'b1;
			@(posedge aclk);
		end
		if (!h)
			tmo();
	endtask
	task automatic ck_irq(input logic e);
		@(negedge aclk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge aclk);
	endtask
	// *******
	// Sequence
	// *******
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(ADDR_CFG, {25'h0, CFG_RST});
		rc(8'h30, 32'h0);
		chk({30'h0, rr}, {30'h0, RESP_DECERR});
		wr(8'h34, 32'h1);
		chk({30'h0, rr}, {30'h0, RESP_DECERR});
		$display("test 1 done");
		wr(ADDR_CAL, CAL);
		wr(ADDR_IMASK, 32'h1);
		wr(ADDR_CFG, 32'h07);
		wait_irq();
		rc(ADDR_CUR, 32'(C));
		rc(ADDR_BUS_VOLTAGE_INPUT, 32'(B));
		rc(ADDR_TEMP, 32'(T));
		rc(ADDR_POW, 32'(P >> 12));
		rc(ADDR_ENER, 32'(P >> 16));
		rc(ADDR_CHRG, 32'(C >> 8));
		rc(ADDR_DIAG, 32'h1);
		rc(ADDR_DIAG, 32'h0);
		wr(ADDR_ISTAT, 32'h3);
		ck_irq(1'b0);
		$display("test 2 done");
		slow <= 1'b1;
		wr(ADDR_ACLR, 32'h1);
		wr(ADDR_CFG, 32'h17);
		wait_irq();
		rc(ADDR_CUR, 32'(C));
		rc(ADDR_BUS_VOLTAGE_INPUT, 32'(B));
		rc(ADDR_POW, 32'(P >> 12));
		rc(ADDR_ENER, 32'((4 * P) >> 16));
		rc(ADDR_CHRG, 32'((4 * C) >> 8));
		$display("test 3 done");
		wr(ADDR_ISTAT, 32'h3);
		wr(ADDR_CAL, 32'h0);
		wr(ADDR_CFG, 32'h07);
		wait_irq();
		rc(ADDR_POW, 32'h0);
		rc(ADDR_ENER, 32'h0);
		rc(ADDR_CHRG, 32'h0);
		$display("test 4 done");
		wr(ADDR_ISTAT, 32'h3);
		wr(ADDR_CFG, 32'h0f);
		wait_irq();
		rc(ADDR_DIAG, 32'h2, 32'h2);
		wr(ADDR_IMASK, 32'h0);
		ck_irq(1'b0);
		rc(ADDR_ISTAT, 32'h1, 32'h1);
		$display("test 5 done");
		conclude();
	end
endmodule
